// [hdl/pmq_top.v]
// PIR motion qualifier: filters, one-shots, mode logic, duration timer, AHB-Lite registers
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pmq_regs.vh"

module pmq_top
#(
    parameter [31:0] FILTER_CYC   = `PMQ_FILTER_MS * `PMQ_CLK_KHZ,
    parameter [31:0] ONESHOT_CYC  = `PMQ_ONESHOT_MS * `PMQ_CLK_KHZ,
    parameter [31:0] WINDOW_CYC   = `PMQ_WINDOW_MS * `PMQ_CLK_KHZ,
    parameter [31:0] DURATION_CYC = `PMQ_DURATION_MS * `PMQ_CLK_KHZ,
    parameter        UV_IGNORE    = 1'b0
)
(
    // Clock, reset, clock enable
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Window comparator outputs
    input  wire        comp_pos,
    input  wire        comp_neg,
    // Three-level mode pin, seen as float and level
    input  wire        mode_float,
    input  wire        mode_level,
    // Enable and undervoltage
    input  wire        enable_n,
    input  wire        uv_sel_float,
    input  wire        uv_sel_level,
    input  wire        uv_flag,
    // Open-drain true and complementary outputs
    input  wire        detect_output_i,
    output wire        detect_output_o,
    output wire        detect_output_oe,
    input  wire        detect_output_n_i,
    output wire        detect_output_n_o,
    output wire        detect_output_n_oe,
    // Interrupt
    output wire        irq
);

    // ------------------------------------------------------------------------
    // Mode state codes
    // ------------------------------------------------------------------------
    localparam [1:0] MODE_SINGLE = `PMQ_MODE_SINGLE;
    localparam [1:0] MODE_CONC   = `PMQ_MODE_CONC;
    localparam [1:0] MODE_DUAL   = `PMQ_MODE_DUAL;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [31:0] filt_tc_q;
    reg  [31:0] os_tc_q;
    reg  [31:0] win_tc_q;
    reg  [31:0] dur_tc_q;
    reg  [4:0]  irq_sts_q;
    reg  [4:0]  irq_sts_d;
    reg  [4:0]  irq_mask_q;
    reg         det_q;
    reg         uv_q;
    reg         wr_pend_q;
    reg  [7:0]  wr_addr_q;

    wire        pos_pulse;
    wire        neg_pulse;
    wire        pos_held;
    wire        neg_held;
    wire        os_pos;
    wire        os_neg;
    wire        win_active;
    wire        dur_active;
    reg  [1:0]  mode_d;
    reg         qual_d;
    wire        any_det;
    wire        two_det;
    wire        uv_resp;
    wire        det_d;

    // ------------------------------------------------------------------------
    // Digital filters, one per polarity
    // ------------------------------------------------------------------------
    pmq_filter u_filt_pos
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .din     (comp_pos),
        .tc      (filt_tc_q),
        .pulse_q (pos_pulse),
        .held_q  (pos_held)
    );

    pmq_filter u_filt_neg
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .din     (comp_neg),
        .tc      (filt_tc_q),
        .pulse_q (neg_pulse),
        .held_q  (neg_held)
    );

    // ------------------------------------------------------------------------
    // Retriggerable one-shots
    // ------------------------------------------------------------------------
    pmq_timer u_os_pos
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .trig    (pos_pulse),
        .clr     (1'b0),
        .tc      (os_tc_q),
        .active  (os_pos)
    );

    pmq_timer u_os_neg
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .trig    (neg_pulse),
        .clr     (1'b0),
        .tc      (os_tc_q),
        .active  (os_neg)
    );

    // ------------------------------------------------------------------------
    // Mode decode and qualification
    // ------------------------------------------------------------------------
    always @*
    begin
        if (mode_float)
            mode_d = MODE_CONC;
        else if (mode_level)
            mode_d = MODE_DUAL;
        else
            mode_d = MODE_SINGLE;
    end

    assign any_det = pos_pulse | neg_pulse;
    // Both polarities in one cycle count as two detections
    assign two_det = pos_pulse & neg_pulse;

    always @*
    begin
        case (mode_d)
            MODE_SINGLE: qual_d = any_det;
            MODE_CONC:   qual_d = os_pos & os_neg;
            MODE_DUAL:   qual_d = two_det | (any_det & win_active);
            default:     qual_d = 1'b0;
        endcase
    end

    // Window opens on a first detection and closes once it has qualified
    pmq_timer u_window
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .trig    (any_det & ~win_active & (mode_d == MODE_DUAL)),
        .clr     (qual_d | (mode_d != MODE_DUAL)),
        .tc      (win_tc_q),
        .active  (win_active)
    );

    // Qualifications while disabled are dropped; one-shots, window and a running duration still carry over into enabling
    pmq_timer u_duration
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .trig    (qual_d & ~enable_n),
        .clr     (1'b0),
        .tc      (dur_tc_q),
        .active  (dur_active)
    );

    // ------------------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------------------
    assign uv_resp = ~UV_IGNORE & ~uv_sel_float & ~uv_sel_level;
    assign det_d   = ~enable_n & (dur_active | (uv_resp & uv_flag));

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            det_q <= 1'b0;
            uv_q  <= 1'b0;
        end
        else if (ce)
        begin
            det_q <= det_d;
            uv_q  <= uv_resp & uv_flag;
        end
    end

    // Open drain: the pin sinks when its enable is high
    assign detect_output_o    = 1'b0;
    assign detect_output_oe   = det_q;
    assign detect_output_n_o  = 1'b0;
    assign detect_output_n_oe = ~det_q;

    // ------------------------------------------------------------------------
    // Interrupt status, set wins over a same-cycle clear
    // ------------------------------------------------------------------------
    wire [4:0] irq_set = {uv_resp & uv_flag & ~uv_q,
                          det_d & ~det_q,
                          qual_d,
                          neg_pulse,
                          pos_pulse};
    wire       wr_now  = wr_pend_q & ce;

    always @*
    begin
        irq_sts_d = irq_sts_q;
        if (wr_now && (wr_addr_q == `PMQ_OFF_IRQ_STS))
            irq_sts_d = irq_sts_d & ~hwdata[`PMQ_IRQ_W-1:0];
        irq_sts_d = irq_sts_d | irq_set;
    end

    assign irq = |(irq_sts_q & irq_mask_q);

    // ------------------------------------------------------------------------
    // AHB-Lite slave: zero wait, reads registered in the address phase
    // ------------------------------------------------------------------------
    // A frozen clock enable stalls the bus rather than dropping a transfer
    assign hreadyout = ce;
    assign hresp     = 1'b0;

    wire       take   = hsel & htrans[1] & hready & ce;
    wire [7:0] a_addr = haddr[7:0];

    reg [31:0] rd_d;
    always @*
    begin
        case (a_addr)
            `PMQ_OFF_STATUS:   rd_d = {20'h00000, detect_output_n_i, detect_output_i,
                                       uv_resp, mode_d, det_q, dur_active,
                                       win_active, os_neg, os_pos, neg_held, pos_held};
            `PMQ_OFF_IRQ_STS:  rd_d = {27'h0000000, irq_sts_q};
            `PMQ_OFF_IRQ_MASK: rd_d = {27'h0000000, irq_mask_q};
            `PMQ_OFF_FILT_TC:  rd_d = filt_tc_q;
            `PMQ_OFF_OS_TC:    rd_d = os_tc_q;
            `PMQ_OFF_WIN_TC:   rd_d = win_tc_q;
            `PMQ_OFF_DUR_TC:   rd_d = dur_tc_q;
            default:           rd_d = 32'h0000_0000;
        endcase
        if (|haddr[31:8])
            rd_d = 32'h0000_0000;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata     <= 32'h0000_0000;
            wr_pend_q  <= 1'b0;
            wr_addr_q  <= 8'h00;
            irq_sts_q  <= 5'h00;
            irq_mask_q <= `PMQ_MASK_RST;
            filt_tc_q  <= FILTER_CYC;
            os_tc_q    <= ONESHOT_CYC;
            win_tc_q   <= WINDOW_CYC;
            dur_tc_q   <= DURATION_CYC;
        end
        else if (ce)
        begin
            irq_sts_q <= irq_sts_d;
            if (take && !hwrite)
                hrdata <= rd_d;
            // Only whole-word writes inside the block are accepted
            wr_pend_q <= take & hwrite & (hsize == 3'h2) & ~(|haddr[31:8]);
            if (take)
                wr_addr_q <= a_addr;
            if (wr_pend_q)
            begin
                case (wr_addr_q)
                    `PMQ_OFF_IRQ_MASK: irq_mask_q <= hwdata[`PMQ_IRQ_W-1:0];
                    `PMQ_OFF_FILT_TC:  filt_tc_q  <= hwdata;
                    `PMQ_OFF_OS_TC:    os_tc_q    <= hwdata;
                    `PMQ_OFF_WIN_TC:   win_tc_q   <= hwdata;
                    `PMQ_OFF_DUR_TC:   dur_tc_q   <= hwdata;
                    default:           ;
                endcase
            end
        end
    end

endmodule // pmq_top

`default_nettype wire

// [hdl/pmq_regs.vh]
// Constants for the PIR motion qualifier: offsets, fields, reset values, timings
// ----------------------------------------------------------------------------
// Functional notes
// - Each polarity filtered separately, continuous-active duration
// - Mode pin: low single, open concurrent, high dual
// - Single mode: any filtered detection qualifies
// - Each detection restarts its own retriggerable one-shot
// - Concurrent mode: both one-shots active together
// - Dual mode: two detections within window qualify
// - Enable high holds outputs dormant
// - Undervoltage select driven low enables undervoltage response
// - Qualified detection starts or restarts duration timer
// - True output sinks while duration timer active
// - Enabled undervoltage flag also asserts the output
// - Complementary output always inverse of true output
// - Build option ignores undervoltage flag entirely
// ----------------------------------------------------------------------------
`ifndef PMQ_REGS_VH
`define PMQ_REGS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PMQ_CLK_KHZ       125000
`define PMQ_FILTER_MS     50
`define PMQ_ONESHOT_MS    1000
`define PMQ_WINDOW_MS     2500
`define PMQ_DURATION_MS   4000

// ----------------------------------------------------------------------------
// Register byte offsets (address bits 7:0)
// ----------------------------------------------------------------------------
`define PMQ_OFF_STATUS    8'h00
`define PMQ_OFF_IRQ_STS   8'h04
`define PMQ_OFF_IRQ_MASK  8'h08
`define PMQ_OFF_FILT_TC   8'h0c
`define PMQ_OFF_OS_TC     8'h10
`define PMQ_OFF_WIN_TC    8'h14
`define PMQ_OFF_DUR_TC    8'h18

// ----------------------------------------------------------------------------
// Interrupt status / mask bits
// ----------------------------------------------------------------------------
`define PMQ_IRQ_POS       0
`define PMQ_IRQ_NEG       1
`define PMQ_IRQ_QUAL      2
`define PMQ_IRQ_OUT       3
`define PMQ_IRQ_UV        4
`define PMQ_IRQ_W         5
`define PMQ_MASK_RST      5'h00

// ----------------------------------------------------------------------------
// Mode codes reported in status bits 8:7
// ----------------------------------------------------------------------------
`define PMQ_MODE_SINGLE   2'h0
`define PMQ_MODE_CONC     2'h1
`define PMQ_MODE_DUAL     2'h2

`endif

// [hdl/pmq_filter.v]
// Continuous-active filter: one pulse after the input has held high for tc cycles
`timescale 1ns/1ps
`default_nettype none

module pmq_filter
(
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    // Input and terminal count
    input  wire        din,
    input  wire [31:0] tc,
    // Result
    output reg         pulse_q,
    output reg         held_q
);

    reg  [31:0] cnt_q;
    wire [31:0] last_w = (tc == 32'h0000_0000) ? 32'h0000_0000 : tc - 32'h0000_0001;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q   <= 32'h0000_0000;
            pulse_q <= 1'b0;
            held_q  <= 1'b0;
        end
        else if (ce)
        begin
            pulse_q <= 1'b0;
            if (!din)
            begin
                // Any drop restarts the wait; short noise never fires
                cnt_q  <= 32'h0000_0000;
                held_q <= 1'b0;
            end
            else if (!held_q)
            begin
                if (cnt_q == last_w)
                begin
                    pulse_q <= 1'b1;
                    held_q  <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                end
            end
        end
    end

endmodule // pmq_filter

`default_nettype wire

// [hdl/pmq_timer.v]
// Retriggerable down-counting timer, active while the count is nonzero
`timescale 1ns/1ps
`default_nettype none

module pmq_timer
(
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    // Control
    input  wire        trig,
    input  wire        clr,
    input  wire [31:0] tc,
    // Result
    output wire        active
);

    reg [31:0] cnt_q;

    assign active = (cnt_q != 32'h0000_0000);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (clr)
            begin
                cnt_q <= 32'h0000_0000;
            end
            else if (trig)
            begin
                // Zero count is treated as one cycle so a trigger is never lost
                cnt_q <= (tc == 32'h0000_0000) ? 32'h0000_0001 : tc;
            end
            else if (active)
            begin
                cnt_q <= cnt_q - 32'h0000_0001;
            end
        end
    end

endmodule // pmq_timer

`default_nettype wire

// [tb/pmq_props.sv]
// Port-level assertions for the PIR motion qualifier
`timescale 1ns/1ps
`default_nettype none
module pmq_props
#(
    parameter [31:0] FILTER_CYC   = 32'h8,
    parameter [31:0] DURATION_CYC = 32'h32,
    parameter        UV_IGNORE    = 1'b0
)
(
    // Clock, reset, bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Detection side
    input wire logic        comp_pos,
    input wire logic        comp_neg,
    input wire logic        mode_float,
    input wire logic        mode_level,
    input wire logic        enable_n,
    input wire logic        uv_sel_float,
    input wire logic        uv_sel_level,
    input wire logic        uv_flag,
    input wire logic        detect_output_o,
    input wire logic        detect_output_oe,
    input wire logic        detect_output_n_o,
    input wire logic        detect_output_n_oe
);
    logic [31:0] pos_run_q;
    logic [31:0] neg_run_q;
    logic [31:0] hi_run_q;
    logic        single_m;
    logic        uv_en;
    logic        rd_take;
    assign single_m = !mode_float && !mode_level;
    assign uv_en    = !UV_IGNORE && !uv_sel_float && !uv_sel_level;
    assign rd_take  = hsel && htrans[1] && !hwrite && hready && ce;

    // Run lengths; the filter only sees enabled cycles
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pos_run_q <= 32'h0;
            neg_run_q <= 32'h0;
            hi_run_q  <= 32'h0;
        end
        else
        begin
            if (ce)
                pos_run_q <= comp_pos ? pos_run_q + 32'h1 : 32'h0;
            if (ce)
                neg_run_q <= comp_neg ? neg_run_q + 32'h1 : 32'h0;
            hi_run_q <= detect_output_oe ? hi_run_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_hit;
        (pos_run_q == FILTER_CYC || neg_run_q == FILTER_CYC) && single_m && !enable_n;
    endsequence
    sequence s_sink;
        ##2 detect_output_oe;
    endsequence
    sequence s_calm;
        (!uv_flag && !enable_n) [*4];
    endsequence

    property p_single_hit;
        s_hit |-> s_sink;
    endproperty
    property p_hold;
        s_calm ##0 $fell(detect_output_oe) |-> hi_run_q >= DURATION_CYC;
    endproperty
    property p_enable;
        enable_n [*2] |-> !detect_output_oe;
    endproperty
    property p_uv;
        (uv_flag && uv_en && !enable_n && ce) [*4] |-> detect_output_oe;
    endproperty
    property p_compl;
        detect_output_n_oe == !detect_output_oe;
    endproperty
    property p_sink;
        !detect_output_o && !detect_output_n_o;
    endproperty
    property p_ready;
        hreadyout == ce;
    endproperty
    property p_okay;
        !hresp;
    endproperty
    property p_rdata;
        !rd_take |=> $stable(hrdata);
    endproperty

    a_single_hit: assert property (p_single_hit)
        else $error("filtered hit did not sink the output");
    a_hold: assert property (p_hold)
        else $error("output dropped before the duration ran out");
    a_enable: assert property (p_enable)
        else $error("output active while disabled");
    a_uv: assert property (p_uv)
        else $error("undervoltage did not force the output");
    a_compl: assert property (p_compl)
        else $error("complementary output not inverse");
    a_sink: assert property (p_sink)
        else $error("output drives high instead of sinking");
    a_ready: assert property (p_ready)
        else $error("hreadyout differs from clock enable");
    a_okay: assert property (p_okay)
        else $error("error response seen");
    a_rdata: assert property (p_rdata)
        else $error("read data changed without a read");
endmodule // pmq_props
`default_nettype wire

// [tb/pmq_pir_model.sv]
// Behavioural sensor and window comparator feeding both polarity lines
`timescale 1ns/1ps
`default_nettype none
module pmq_pir_model
(
    // Clock
    input  wire logic hclk,
    // Comparator outputs, idle low
    output var  logic comp_pos,
    output var  logic comp_neg
);
    initial
    begin
        comp_pos = 1'b0;
        comp_neg = 1'b0;
    end

    // Holds one polarity high for len sampled edges, then gap quiet edges
    task automatic burst(input logic neg, input int len, input int gap);
        repeat (len)
        begin
            @(posedge hclk);
            if (neg)
                comp_neg <= 1'b1;
            else
                comp_pos <= 1'b1;
        end
        @(posedge hclk);
        comp_pos <= 1'b0;
        comp_neg <= 1'b0;
        repeat (gap) @(posedge hclk);
    endtask
endmodule // pmq_pir_model
`default_nettype wire

// [tb/test_pir_motion_qualifier.sv]
// Self-checking bench for the PIR motion qualifier
`timescale 1ns/1ps
`default_nettype none
`include "pmq_regs.vh"
module test_pir_motion_qualifier;
    localparam int FILT = 8;
    localparam int DUR  = 50;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        mode_float = 1'b0;
    logic        mode_level = 1'b0;
    logic        enable_n = 1'b0;
    logic        uv_sel_float = 1'b1;
    logic        uv_sel_level = 1'b1;
    logic        uv_flag = 1'b0;
    logic [31:0] rd;
    logic [31:0] rnd;
    int          g;
    int          hi_cnt = 0;
    int          mismatches = 0;
    int          check_count = 0;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic [31:0] hrdata;
    wire logic        comp_pos;
    wire logic        comp_neg;
    wire logic        detect_output_o;
    wire logic        detect_output_oe;
    wire logic        detect_output_n_o;
    wire logic        detect_output_n_oe;
    wire logic        irq;
    wire logic        uvi_oe;
    wire logic        uvi_rdy;
    // Open-drain pins with pull-ups
    wire logic pin_t = detect_output_oe ? detect_output_o : 1'b1;
    wire logic pin_c = detect_output_n_oe ? detect_output_n_o : 1'b1;

    always #4 hclk = ~hclk;
    always @(posedge hclk)
        if (detect_output_oe === 1'b1)
            hi_cnt <= hi_cnt + 1;

    pmq_pir_model pir (.hclk, .comp_pos, .comp_neg);
    pmq_top #(.FILTER_CYC(FILT), .ONESHOT_CYC(40), .WINDOW_CYC(30), .DURATION_CYC(DUR)) DUT
    (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .comp_pos, .comp_neg,
        .mode_float, .mode_level, .enable_n, .uv_sel_float, .uv_sel_level, .uv_flag,
        .detect_output_i(pin_t), .detect_output_o, .detect_output_oe,
        .detect_output_n_i(pin_c), .detect_output_n_o, .detect_output_n_oe, .irq
    );
    // Variant built to ignore undervoltage, fed the same detection inputs
    pmq_top #(.FILTER_CYC(FILT), .ONESHOT_CYC(40), .WINDOW_CYC(30), .DURATION_CYC(DUR),
        .UV_IGNORE(1'b1)) uvi
    (
        .hclk, .hresetn, .ce, .hsel(1'b0), .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(uvi_rdy), .hreadyout(uvi_rdy), .hresp(), .hrdata(), .comp_pos, .comp_neg,
        .mode_float, .mode_level, .enable_n, .uv_sel_float, .uv_sel_level, .uv_flag,
        .detect_output_i(1'b1), .detect_output_o(), .detect_output_oe(uvi_oe),
        .detect_output_n_i(1'b1), .detect_output_n_o(), .detect_output_n_oe(), .irq()
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    function automatic int exp_len(int gap);
        return DUR + FILT + 1 + gap;
    endfunction

    // Waits until the output and all one-shots have settled
    task automatic quiet();
        int lo;
        int n;
        lo = 0;
        n = 0;
        while (lo < 64 && n < 3000)
        begin
            @(posedge hclk);
            lo = detect_output_oe ? 0 : lo + 1;
            n++;
        end
        chk("settle", 32'(n < 3000), 32'h1);
    endtask

    // A negative expectation means longer than one duration
    task automatic shot(input logic mf, ml, n1, n2, input int l1, gap, two, exp);
        int h0;
        mode_float <= mf;
        mode_level <= ml;
        @(posedge hclk);
        h0 = hi_cnt;
        pir.burst(n1, l1, gap);
        if (two)
            pir.burst(n2, FILT, 0);
        quiet();
        if (exp < 0)
            chk("oe_long", 32'(hi_cnt - h0 > DUR), 32'h1);
        else
            chk("oe_len", hi_cnt - h0, exp);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #(8 * 30000);
        mismatches++;
        end_sim();
    end

    initial
    begin
        rnd = $urandom(32'h8fac);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `PMQ_OFF_FILT_TC, 0, rd);
        chk("filt_tc", rd, FILT);
        ahb(1'b0, `PMQ_OFF_DUR_TC, 0, rd);
        chk("dur_tc", rd, DUR);
        ahb(1'b0, `PMQ_OFF_IRQ_MASK, 0, rd);
        chk("mask_rst", rd, 32'h0);
        ahb(1'b0, 32'h40, 0, rd);
        chk("unmapped", rd, 32'h0);
        rnd = $urandom & 32'h1f;
        ahb(1'b1, `PMQ_OFF_IRQ_MASK, rnd, rd);
        ahb(1'b0, `PMQ_OFF_IRQ_MASK, 0, rd);
        chk("mask_rw", rd, rnd);
        ahb(1'b1, `PMQ_OFF_IRQ_MASK, 32'h4, rd);
        ce <= 1'b0;
        @(posedge hclk);
        chk("stall", hreadyout, 1'b0);
        ce <= 1'b1;
        for (int i = 0; i < 4; i++)
            shot(0, 0, i[0], 0, $urandom_range(FILT - 1, 1), 0, 0, 0);
        chk("irq_idle", irq, 1'b0);
        shot(0, 0, 0, 0, FILT, 0, 0, DUR);
        chk("irq_set", irq, 1'b1);
        // Clear under the qualification-only mask (0x4) so a stuck qualification bit would show on irq
        ahb(1'b1, `PMQ_OFF_IRQ_STS, 32'h1f, rd);
        @(posedge hclk);
        chk("irq_clr", irq, 1'b0);
        ahb(1'b1, `PMQ_OFF_IRQ_MASK, 32'h0, rd);
        shot(0, 0, 1, 0, FILT + 5, 0, 0, DUR);
        g = $urandom_range(20, 0);
        shot(0, 0, 0, 1, FILT, g, 1, exp_len(g));
        ahb(1'b0, `PMQ_OFF_IRQ_STS, 0, rd);
        chk("sts", rd, 32'hf);
        chk("irq_mask", irq, 1'b0);
        shot(1, 0, 0, 0, FILT, 0, 0, 0);
        // Level high too: the open pin must win, dual would give one duration only
        shot(1, 1, 0, 1, FILT, 5, 1, -1);
        shot(0, 1, 1, 0, FILT, 0, 0, 0);
        g = $urandom_range(15, 0);
        shot(0, 1, 0, 1, FILT, g, 1, DUR);
        shot(0, 1, 1, 1, FILT, 40, 1, 0);
        // Dual mode in bits 8:7, released true pin reads high in bit 10
        ahb(1'b0, `PMQ_OFF_STATUS, 0, rd);
        chk("status", rd, 32'h500);
        enable_n <= 1'b1;
        shot(0, 0, 0, 0, FILT, 0, 0, 0);
        enable_n <= 1'b0;
        uv_sel_float <= 1'b0;
        uv_sel_level <= 1'b0;
        uv_flag <= 1'b1;
        repeat (6) @(posedge hclk);
        chk("uv_on", detect_output_oe, 1'b1);
        chk("uv_ign", uvi_oe, 1'b0);
        chk("uv_pin", pin_c, 1'b1);
        uv_flag <= 1'b0;
        quiet();
        uv_sel_float <= 1'b1;
        uv_flag <= 1'b1;
        repeat (6) @(posedge hclk);
        chk("uv_off", detect_output_oe, 1'b0);
        uv_flag <= 1'b0;
        end_sim();
    end
endmodule // test_pir_motion_qualifier

bind pmq_top pmq_props #(.FILTER_CYC(FILTER_CYC), .DURATION_CYC(DURATION_CYC),
    .UV_IGNORE(UV_IGNORE)) u_props
(
    .hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .comp_pos, .comp_neg, .mode_float, .mode_level, .enable_n,
    .uv_sel_float, .uv_sel_level, .uv_flag, .detect_output_o, .detect_output_oe,
    .detect_output_n_o, .detect_output_n_oe
);
`default_nettype wire
